// file: shared/towg_consts.vh
`ifndef TOWG_CONSTS_VH
`define TOWG_CONSTS_VH

// register offsets (byte addresses on the plain port)
`define TOWG_ADDR_CTL_M 4'h0
`define TOWG_ADDR_CTL_M1 4'h4
`define TOWG_ADDR_STAT 4'h8
`define TOWG_ADDR_EVT 4'hc

// control register field positions
`define TOWG_BIT_COMP_OR_CAPTURE_SELECT 0
`define TOWG_BIT_POL 1
`define TOWG_BIT_MODE_LO 2
`define TOWG_BIT_MODE_HI 4
`define TOWG_BIT_SWLVL 5
`define TOWG_BIT_PAIR 6
`define TOWG_CTL_WMASK 16'h007f
`define TOWG_CTL_RESET 16'h0000

// output generation modes
`define TOWG_MD_SW 3'h0
`define TOWG_MD_SET 3'h1
`define TOWG_MD_TGLRST 3'h2
`define TOWG_MD_SETRST 3'h3
`define TOWG_MD_TGL 3'h4
`define TOWG_MD_RST 3'h5
`define TOWG_MD_TGLSET 3'h6
`define TOWG_MD_RSTSET 3'h7

// counter direction encoding
`define TOWG_CNT_UP 2'h0
`define TOWG_CNT_DOWN 2'h1
`define TOWG_CNT_UPDOWN 2'h2

`endif

// file: rtl/towg_out_cell.v
`timescale 1ns/100ps
`include "towg_consts.vh"

// one output state bit; events are already selected by the caller
module towg_out_cell (
    input wire mclk_i,
    input wire rst_i,
    input wire enable_i,
    input wire set_i,
    input wire clr_i,
    input wire tgl_i,
    input wire pol_i,
    output reg wave_o
);

    reg active_q;
    reg active_d;

    // clear beats set beats toggle when events coincide in one cycle
    always @* begin
        active_d = active_q;
        if (enable_i) begin
            if (clr_i)
                active_d = 1'b0;
            else if (set_i)
                active_d = 1'b1;
            else if (tgl_i)
                active_d = ~active_q;
        end
    end

    // state starts inactive and holds when nothing fires
    always @(posedge mclk_i) begin
        if (rst_i)
            active_q <= 1'b0;
        else
            active_q <= active_d;
    end

    // pin level from polarity, registered so the data output is clean;
    // frozen while disabled so a polarity change waits for comparator mode
    always @(posedge mclk_i) begin
        if (rst_i)
            wave_o <= 1'b0;
        else if (enable_i)
            wave_o <= active_d ^ pol_i;
    end

endmodule // towg_out_cell

// file: rtl/towg_top.v
`timescale 1ns/100ps
`include "towg_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// output waveform generator for one comparator pair (m, m+1)
////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - mode 0 drives the output from the software level bit, any count mode.
// - level bit and mode field are ignored while in capture mode.
// - mode 7: match clears, max/zero sets; pair: m clears, m+1 sets.
// - mode 6: match toggles, max/zero sets; pair: m toggles, m+1 sets.
// - mode 5: match clears; pair: either match clears both outputs.
// - mode 4: match toggles; pair: exactly one match toggles both outputs, two matches in one cycle cancel.
// - mode 3: match sets, max/zero clears; pair: m sets, m+1 clears.
// - mode 2: match toggles, max/zero clears; pair: m toggles, m+1 clears.
// - mode 1: match sets; pair: either match sets both outputs.
// - pair bit uses both comparators' matches instead of max/zero events.
// - polarity bit one inverts the pin level, zero keeps it active high.
// - select bit zero means comparator mode; output works only there.
module towg_top (
    input wire mclk_i,
    input wire rst_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire [1:0] cnt_mode_i,
    input wire match_m_i,
    input wire match_m1_i,
    input wire cnt_max_i,
    input wire cnt_zero_i,
    output wire timer_wave_out_m_o,
    output wire timer_wave_out_m1_o
);

    ////////////////////////////////////////////////////////////////////////////
    // control registers for circuit m and m+1
    ////////////////////////////////////////////////////////////////////////////

    reg [15:0] ctl_q [0:1];
    reg [1:0] evt_seen_q;
    integer i;

    // only the implemented low bits store; the rest read as zero
    always @(posedge mclk_i) begin
        if (rst_i) begin
            for (i = 0; i < 2; i = i + 1)
                ctl_q[i] <= `TOWG_CTL_RESET;
        end else if (wr_i) begin
            if (addr_i == `TOWG_ADDR_CTL_M)
                ctl_q[0] <= wdata_i & `TOWG_CTL_WMASK;
            else if (addr_i == `TOWG_ADDR_CTL_M1)
                ctl_q[1] <= wdata_i & `TOWG_CTL_WMASK;
        end
    end

    // field decode helpers
    function [2:0] f_mode;
        input [15:0] c;
        begin
            f_mode = c[`TOWG_BIT_MODE_HI:`TOWG_BIT_MODE_LO];
        end
    endfunction

    function f_cmp;
        input [15:0] c;
        begin
            f_cmp = ~c[`TOWG_BIT_COMP_OR_CAPTURE_SELECT];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // event selection
    ////////////////////////////////////////////////////////////////////////////

    // period event: zero in down counting, max otherwise
    wire period_evt;
    assign period_evt = (cnt_mode_i == `TOWG_CNT_DOWN) ? cnt_zero_i : cnt_max_i;

    reg [1:0] set_e;
    reg [1:0] clr_e;
    reg [1:0] tgl_e;
    reg [1:0] en_e;

    // compute set/clear/toggle for one output from own and partner match
    task sel_events;
        input [15:0] c;
        input own;
        input other;
        input per;
        output s;
        output r;
        output t;
        reg pair;
        reg any;
        reg sec;
        begin
            pair = c[`TOWG_BIT_PAIR];
            sec = pair ? other : per;
            any = own | (pair & other);
            s = 1'b0;
            r = 1'b0;
            t = 1'b0;
            case (f_mode(c))
                `TOWG_MD_SW: begin
                    s = c[`TOWG_BIT_SWLVL];
                    r = ~c[`TOWG_BIT_SWLVL];
                end
                `TOWG_MD_SET: s = any;
                `TOWG_MD_TGLRST: begin
                    t = own;
                    r = sec;
                end
                `TOWG_MD_SETRST: begin
                    s = own;
                    r = sec;
                end
                `TOWG_MD_TGL: t = own ^ (pair & other);
                `TOWG_MD_RST: r = any;
                `TOWG_MD_TGLSET: begin
                    t = own;
                    s = sec;
                end
                `TOWG_MD_RSTSET: begin
                    r = own;
                    s = sec;
                end
                default: begin
                    s = 1'b0;
                end
            endcase
        end
    endtask

    // partner role mirrors own role with matches swapped
    always @* begin
        sel_events(ctl_q[0], match_m_i, match_m1_i, period_evt, set_e[0], clr_e[0], tgl_e[0]);
        sel_events(ctl_q[1], match_m1_i, match_m_i, period_evt, set_e[1], clr_e[1], tgl_e[1]);
        en_e[0] = f_cmp(ctl_q[0]);
        en_e[1] = f_cmp(ctl_q[1]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // output cells
    ////////////////////////////////////////////////////////////////////////////

    towg_out_cell u_cell_m (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(en_e[0]),
        .set_i(set_e[0]),
        .clr_i(clr_e[0]),
        .tgl_i(tgl_e[0]),
        .pol_i(ctl_q[0][`TOWG_BIT_POL]),
        .wave_o(timer_wave_out_m_o)
    );

    towg_out_cell u_cell_m1 (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(en_e[1]),
        .set_i(set_e[1]),
        .clr_i(clr_e[1]),
        .tgl_i(tgl_e[1]),
        .pol_i(ctl_q[1][`TOWG_BIT_POL]),
        .wave_o(timer_wave_out_m1_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sticky match seen flags, cleared by writing ones; set wins
    ////////////////////////////////////////////////////////////////////////////

    always @(posedge mclk_i) begin
        if (rst_i)
            evt_seen_q <= 2'h0;
        else
            evt_seen_q <= (evt_seen_q & ~((wr_i && addr_i == `TOWG_ADDR_EVT) ? wdata_i[1:0] : 2'h0))
                          | {match_m1_i, match_m_i};
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe, zero otherwise
    ////////////////////////////////////////////////////////////////////////////

    always @(posedge mclk_i) begin
        if (rst_i)
            rdata_o <= 16'h0000;
        else if (rd_i) begin
            case (addr_i)
                `TOWG_ADDR_CTL_M: rdata_o <= ctl_q[0];
                `TOWG_ADDR_CTL_M1: rdata_o <= ctl_q[1];
                `TOWG_ADDR_STAT: rdata_o <= {14'h0000, timer_wave_out_m1_o, timer_wave_out_m_o};
                `TOWG_ADDR_EVT: rdata_o <= {14'h0000, evt_seen_q};
                default: rdata_o <= 16'h0000;
            endcase
        end else
            rdata_o <= 16'h0000;
    end

endmodule // towg_top

// file: sim/towg_evt_model.sv
`timescale 1ns/100ps
////////////////////////////////////////
// stand-in for the channel counter and comparators
module towg_evt_model (
    input wire mclk_i,
    input wire rst_i,
    input wire [3:0] fire_i,
    output reg match_m_o,
    output reg match_m1_o,
    output reg cnt_max_o,
    output reg cnt_zero_o
);
    // one-cycle pulses a cycle after the request, never held over
    always @(posedge mclk_i) begin
        if (rst_i)
            {cnt_zero_o, cnt_max_o, match_m1_o, match_m_o} <= 4'h0;
        else
            {cnt_zero_o, cnt_max_o, match_m1_o, match_m_o} <= fire_i;
    end
endmodule // towg_evt_model

// file: sim/towg_top_monitor.sv
`timescale 1ns/100ps
module towg_top_monitor (
    input wire mclk_i, input wire rst_i, input wire [3:0] addr_i, input wire [15:0] wdata_i,
    input wire wr_i, input wire rd_i, input wire [15:0] rdata_o, input wire [1:0] cnt_mode_i,
    input wire match_m_i, input wire match_m1_i, input wire cnt_max_i, input wire cnt_zero_i,
    input wire timer_wave_out_m_o, input wire timer_wave_out_m1_o
);
    reg [6:0] ctl_q;
    wire wm = wr_i && addr_i == 4'h0;
    wire act = wr_i | match_m_i | match_m1_i | cnt_max_i | cnt_zero_i;
    // shadow of control m, written only by the bus
    always @(posedge mclk_i) begin
        if (rst_i)
            ctl_q <= 7'h00;
        else if (wm)
            ctl_q <= wdata_i[6:0];
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_ctl_wr_rd;
        wm ##1 (rd_i && addr_i == 4'h0);
    endsequence
    a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside read");
    a_unmapped_read: assert property ($past(rd_i && addr_i[1:0] != 2'h0) |-> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_ctl_upper_zero: assert property ($past(rd_i && addr_i[3] == 1'b0 && addr_i[1:0] == 2'h0) |-> rdata_o[15:7] == 9'h000)
        else $error("control upper bits not zero");
    a_wr_readback: assert property (s_ctl_wr_rd |=> rdata_o == ($past(wdata_i, 2) & 16'h007f))
        else $error("control readback mismatch");
    a_status_pins: assert property ($past(rd_i && addr_i == 4'h8) |->
        rdata_o == {14'h0000, $past(timer_wave_out_m1_o), $past(timer_wave_out_m_o)})
        else $error("status differs from pins");
    a_quiet_hold: assert property (!$past(act) && !$past(act, 2) |->
        $stable(timer_wave_out_m_o) && $stable(timer_wave_out_m1_o))
        else $error("output moved without event");
    a_capture_freeze: assert property (ctl_q[0] && $past(ctl_q[0]) && $past(ctl_q[0], 2) |->
        $stable(timer_wave_out_m_o))
        else $error("output moved in capture mode");
    a_sw_level: assert property (ctl_q[4:0] == 5'h00 && !$past(wm) && !$past(wm, 2) |->
        timer_wave_out_m_o == ctl_q[5])
        else $error("software level not on output");
endmodule // towg_top_monitor
bind towg_top towg_top_monitor i_towg_top_monitor (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cnt_mode_i(cnt_mode_i),
    .match_m_i(match_m_i), .match_m1_i(match_m1_i), .cnt_max_i(cnt_max_i), .cnt_zero_i(cnt_zero_i),
    .timer_wave_out_m_o(timer_wave_out_m_o), .timer_wave_out_m1_o(timer_wave_out_m1_o));

// file: sim/timer_output_waveform_gen_bench.sv
`timescale 1ns/100ps
`include "towg_consts.vh"
module timer_output_waveform_gen_bench;
    reg mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
    reg [3:0] addr_i = 4'h0, fire = 4'h0, f = 4'h0;
    wire pm, pm1;
    reg [15:0] wdata_i = 16'h0000, c0, c1, e;
    reg [1:0] cnt_mode_i = 2'h0, st = 2'h0, pin = 2'h0;
    wire [15:0] rdata_o;
    wire mm, mm1, mx, mz;
    int err_count = 0, checked = 0, cyc = 0;
    reg [15:0] exp_q[$];
    towg_top i_towg_top (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .cnt_mode_i(cnt_mode_i), .match_m_i(mm), .match_m1_i(mm1),
        .cnt_max_i(mx), .cnt_zero_i(mz), .timer_wave_out_m_o(pm), .timer_wave_out_m1_o(pm1));
    towg_evt_model i_towg_evt_model (.mclk_i(mclk_i), .rst_i(rst_i), .fire_i(fire), .match_m_o(mm),
        .match_m1_o(mm1), .cnt_max_o(mx), .cnt_zero_o(mz));
    // reference next state; clear beats set beats toggle
    function automatic logic step(input [15:0] c, input logic s, own, oth, emx, emz, input [1:0] cm);
        logic b, set, clr, tgl, po;
        po = c[6] & oth;
        b = c[6] ? oth : (cm == `TOWG_CNT_DOWN ? emz : emx);
        {set, clr, tgl} = 3'h0;
        case (c[4:2])
            `TOWG_MD_SW: {set, clr} = {c[5], ~c[5]};
            `TOWG_MD_RSTSET: {clr, set} = {own, b};
            `TOWG_MD_TGLSET: {tgl, set} = {own, b};
            `TOWG_MD_RST: clr = own | po;
            `TOWG_MD_TGL: tgl = own ^ po;
            `TOWG_MD_SETRST: {set, clr} = {own, b};
            `TOWG_MD_TGLRST: {tgl, clr} = {own, b};
            default: set = own | po;
        endcase
        step = clr ? 1'b0 : set ? 1'b1 : tgl ? ~s : s;
    endfunction
    // one bus cycle; every signal assigned once per edge
    task automatic bus(input logic w, input logic r, input [3:0] a, input [15:0] d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
    endtask
    task automatic rd(input [3:0] a, input [15:0] x);
        exp_q.push_back(x);
        bus(1'b0, 1'b1, a, 16'h0000);
    endtask
    task results;
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // clock at 10 MHz
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    // hang guard and read-data scoreboard
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
        if (rd_d) begin
            e = exp_q.pop_front();
            checked++;
            if (rdata_o !== e) begin
                err_count++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, rdata_o, e);
            end
        end
        rd_d <= rd_i;
    end
    // random control words and events, pins read back through status
    initial begin
        void'($urandom(32'h86e5a214));
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(`TOWG_ADDR_STAT, 16'h0000);
        rd(4'h2, 16'h0000);
        for (int i = 0; i < 400; i++) begin
            c0 = $urandom;
            c1 = $urandom;
            c0[0] = ($urandom % 4 == 0);
            c1[0] = ($urandom % 4 == 0);
            cnt_mode_i <= 2'($urandom % 3);
            bus(1'b1, 1'b0, `TOWG_ADDR_CTL_M1, c1);
            bus(1'b1, 1'b0, `TOWG_ADDR_CTL_M, c0);
            rd(`TOWG_ADDR_CTL_M, c0 & `TOWG_CTL_WMASK);
            f = 4'($urandom);
            fire <= f;
            bus(1'b0, 1'b0, 4'h0, 16'h0000);
            fire <= 4'h0;
            repeat (3) bus(1'b0, 1'b0, 4'h0, 16'h0000);
            if (!c0[0])
                st[0] = step(c0, st[0], f[0], f[1], f[2], f[3], cnt_mode_i);
            if (!c1[0])
                st[1] = step(c1, st[1], f[1], f[0], f[2], f[3], cnt_mode_i);
            if (!c0[0])
                pin[0] = st[0] ^ c0[1];
            if (!c1[0])
                pin[1] = st[1] ^ c1[1];
            // pins themselves, settled after the idle cycles
            checked++;
            if ({pm1, pm} !== pin) begin
                err_count++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, {pm1, pm}, pin);
            end
            rd(`TOWG_ADDR_STAT, {14'h0000, pin});
            // sticky match flags, then clear them by writing ones
            rd(`TOWG_ADDR_EVT, {14'h0000, f[1:0]});
            bus(1'b1, 1'b0, `TOWG_ADDR_EVT, 16'h0003);
        end
        repeat (3) bus(1'b0, 1'b0, 4'h0, 16'h0000);
        results();
    end
endmodule // timer_output_waveform_gen_bench
